// File: rtl/usoc_top.v
// Purpose: dual channel status registers, output pin configuration and interrupt
// Assumes: one 20 MHz clock, synchronous active low reset, host port synchronous
// Notes: read data stand in the cycle after the read strobe only
`timescale 1ns/100ps
`include "usoc_regs.vh"

module usoc_top #(
    parameter DEPTH = `USOC_DEPTH_DEEP,
    parameter AW = 4
) (
    // clock and reset
    input wire I_MCLK,
    input wire I_RST_N,
    // register port
    input wire [3:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    output wire [7:0] O_RDATA,
    // channel A receive and transmit
    input wire I_RXA_VALID,
    input wire [7:0] I_RXA_DATA,
    input wire [2:0] I_RXA_ERR,
    input wire I_TXA_TAKE,
    output wire O_TXA_VALID,
    output wire [7:0] O_TXA_DATA,
    // channel B receive and transmit
    input wire I_RXB_VALID,
    input wire [7:0] I_RXB_DATA,
    input wire [2:0] I_RXB_ERR,
    input wire I_TXB_TAKE,
    output wire O_TXB_VALID,
    output wire [7:0] O_TXB_DATA,
    // general output pins
    output wire [7:0] O_OP_OUT,
    output wire [7:0] O_OP_OE_N,
    // interrupt
    output wire O_IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    // registers

    reg [7:0] mode_a_q;
    reg [7:0] mode_b_q;
    reg [7:0] pin_cfg_q;
    reg [7:0] opv_q;
    reg [3:0] evt_q;
    reg [3:0] mask_q;
    reg [7:0] rdata_q;
    reg [7:0] op_out_q;
    reg [7:0] op_oen_q;
    reg irq_q;
    reg txa_vld_q;
    reg txb_vld_q;
    reg [7:0] txa_dat_q;
    reg [7:0] txb_dat_q;
    reg rdy_a_prev_q;
    reg rdy_b_prev_q;
    reg ovr_a_prev_q;
    reg ovr_b_prev_q;

    reg [7:0] rdata_d;
    reg [7:0] op_out_d;
    reg [7:0] op_oen_d;
    reg [3:0] evt_d;

    wire [7:0] st_a;
    wire [7:0] st_b;
    wire [7:0] rxa_dat;
    wire [7:0] rxb_dat;
    wire txa_vld;
    wire txb_vld;
    wire [7:0] txa_dat;
    wire [7:0] txb_dat;
    wire [7:0] int_st;

    ////////////////////////////////////////////////////////////////////////////
    // address decode and command strobes

    wire wr_cmd_a = I_WR & (I_ADDR == `USOC_A_CMD_A);
    wire wr_cmd_b = I_WR & (I_ADDR == `USOC_A_CMD_B);
    wire [3:0] code = I_WDATA[`USOC_CMD_CODE];
    wire rx_rst_a = wr_cmd_a & (code == `USOC_CMD_RX_RST);
    wire tx_rst_a = wr_cmd_a & (code == `USOC_CMD_TX_RST);
    wire err_rst_a = wr_cmd_a & (code == `USOC_CMD_ERR_RST);
    wire rx_rst_b = wr_cmd_b & (code == `USOC_CMD_RX_RST);
    wire tx_rst_b = wr_cmd_b & (code == `USOC_CMD_TX_RST);
    wire err_rst_b = wr_cmd_b & (code == `USOC_CMD_ERR_RST);
    wire tx_en_a = wr_cmd_a & I_WDATA[`USOC_CMD_TX_EN];
    wire tx_dis_a = wr_cmd_a & I_WDATA[`USOC_CMD_TX_DIS];
    wire tx_en_b = wr_cmd_b & I_WDATA[`USOC_CMD_TX_EN];
    wire tx_dis_b = wr_cmd_b & I_WDATA[`USOC_CMD_TX_DIS];
    wire rd_data_a = I_RD & (I_ADDR == `USOC_A_DATA_A);
    wire rd_data_b = I_RD & (I_ADDR == `USOC_A_DATA_B);
    wire wr_data_a = I_WR & (I_ADDR == `USOC_A_DATA_A);
    wire wr_data_b = I_WR & (I_ADDR == `USOC_A_DATA_B);

    ////////////////////////////////////////////////////////////////////////////
    // channels

    usoc_chan #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_chan_a (
        .clk(I_MCLK),
        .rst_n(I_RST_N),
        .i_fifo8(mode_a_q[`USOC_MODE_FIFO8]),
        .i_blk_mode(mode_a_q[`USOC_MODE_BLK]),
        .i_rx_rst(rx_rst_a),
        .i_tx_rst(tx_rst_a),
        .i_err_rst(err_rst_a),
        .i_tx_en(tx_en_a),
        .i_tx_dis(tx_dis_a),
        .i_rx_valid(I_RXA_VALID),
        .i_rx_data(I_RXA_DATA),
        .i_rx_err(I_RXA_ERR),
        .i_rd(rd_data_a),
        .o_rx_data(rxa_dat),
        .i_wr(wr_data_a),
        .i_wdata(I_WDATA),
        .i_tx_take(I_TXA_TAKE),
        .o_tx_valid(txa_vld),
        .o_tx_data(txa_dat),
        .o_status(st_a)
    );

    // same layout as channel A, fed by the channel B receiver and transmitter
    usoc_chan #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_chan_b (
        .clk(I_MCLK),
        .rst_n(I_RST_N),
        .i_fifo8(mode_b_q[`USOC_MODE_FIFO8]),
        .i_blk_mode(mode_b_q[`USOC_MODE_BLK]),
        .i_rx_rst(rx_rst_b),
        .i_tx_rst(tx_rst_b),
        .i_err_rst(err_rst_b),
        .i_tx_en(tx_en_b),
        .i_tx_dis(tx_dis_b),
        .i_rx_valid(I_RXB_VALID),
        .i_rx_data(I_RXB_DATA),
        .i_rx_err(I_RXB_ERR),
        .i_rd(rd_data_b),
        .o_rx_data(rxb_dat),
        .i_wr(wr_data_b),
        .i_wdata(I_WDATA),
        .i_tx_take(I_TXB_TAKE),
        .o_tx_valid(txb_vld),
        .o_tx_data(txb_dat),
        .o_status(st_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: receive bit shows full or ready depending on mode bit 6

    assign int_st[0] = st_a[`USOC_ST_TXRDY];
    assign int_st[1] = mode_a_q[`USOC_MODE_RXINT] ? st_a[`USOC_ST_FULL] : st_a[`USOC_ST_RDY];
    assign int_st[3:2] = 2'h0;
    assign int_st[4] = st_b[`USOC_ST_TXRDY];
    assign int_st[5] = mode_b_q[`USOC_MODE_RXINT] ? st_b[`USOC_ST_FULL] : st_b[`USOC_ST_RDY];
    assign int_st[7:6] = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // writable registers

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            mode_a_q <= `USOC_BYTE_RST;
            mode_b_q <= `USOC_BYTE_RST;
            pin_cfg_q <= `USOC_BYTE_RST;
            opv_q <= `USOC_BYTE_RST;
            mask_q <= `USOC_EVT_RST;
        end else if (I_WR) begin
            case (I_ADDR)
                `USOC_A_MODE_A: begin
                    mode_a_q <= I_WDATA;
                end
                `USOC_A_MODE_B: begin
                    mode_b_q <= I_WDATA;
                end
                `USOC_A_PINCFG: begin
                    pin_cfg_q <= I_WDATA;
                end
                `USOC_A_OPV: begin
                    opv_q <= I_WDATA;
                end
                `USOC_A_MASK: begin
                    mask_q <= I_WDATA[3:0];
                end
                default: begin
                    mask_q <= mask_q;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky events, write one to clear, a new event wins over the clear

    always @* begin
        evt_d = evt_q;
        if (I_WR && (I_ADDR == `USOC_A_EVT)) begin
            evt_d = evt_q & ~I_WDATA[3:0];
        end
        evt_d[`USOC_EV_RDY_A] = evt_d[`USOC_EV_RDY_A] | (st_a[`USOC_ST_RDY] & ~rdy_a_prev_q);
        evt_d[`USOC_EV_OVR_A] = evt_d[`USOC_EV_OVR_A] | (st_a[`USOC_ST_OVR] & ~ovr_a_prev_q);
        evt_d[`USOC_EV_RDY_B] = evt_d[`USOC_EV_RDY_B] | (st_b[`USOC_ST_RDY] & ~rdy_b_prev_q);
        evt_d[`USOC_EV_OVR_B] = evt_d[`USOC_EV_OVR_B] | (st_b[`USOC_ST_OVR] & ~ovr_b_prev_q);
    end

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            evt_q <= `USOC_EVT_RST;
            irq_q <= 1'b0;
            rdy_a_prev_q <= 1'b0;
            rdy_b_prev_q <= 1'b0;
            ovr_a_prev_q <= 1'b0;
            ovr_b_prev_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            irq_q <= |(evt_d & mask_q);
            rdy_a_prev_q <= st_a[`USOC_ST_RDY];
            rdy_b_prev_q <= st_b[`USOC_ST_RDY];
            ovr_a_prev_q <= st_a[`USOC_ST_OVR];
            ovr_b_prev_q <= st_b[`USOC_ST_OVR];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path, data valid in the cycle after the strobe

    always @* begin
        case (I_ADDR)
            `USOC_A_MODE_A: begin
                rdata_d = mode_a_q;
            end
            `USOC_A_STAT_A: begin
                rdata_d = st_a;
            end
            `USOC_A_DATA_A: begin
                rdata_d = rxa_dat;
            end
            `USOC_A_EVT: begin
                rdata_d = {4'h0, evt_q};
            end
            `USOC_A_MASK: begin
                rdata_d = {4'h0, mask_q};
            end
            `USOC_A_INTST: begin
                rdata_d = int_st;
            end
            `USOC_A_OPV: begin
                rdata_d = opv_q;
            end
            `USOC_A_MODE_B: begin
                rdata_d = mode_b_q;
            end
            `USOC_A_STAT_B: begin
                rdata_d = st_b;
            end
            `USOC_A_DATA_B: begin
                rdata_d = rxb_dat;
            end
            `USOC_A_PINCFG: begin
                rdata_d = pin_cfg_q;
            end
            default: begin
                rdata_d = `USOC_BYTE_RST;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // output pins: inverse of the port value, or open drain interrupt status

    always @* begin
        op_out_d = ~opv_q;
        op_oen_d = 8'h00;
        if (pin_cfg_q[7]) begin
            op_out_d[7] = 1'b0;
            op_oen_d[7] = ~int_st[4];
        end
        if (pin_cfg_q[6]) begin
            op_out_d[6] = 1'b0;
            op_oen_d[6] = ~int_st[0];
        end
        if (pin_cfg_q[5]) begin
            op_out_d[5] = 1'b0;
            op_oen_d[5] = ~int_st[5];
        end
        if (pin_cfg_q[4]) begin
            op_out_d[4] = 1'b0;
            op_oen_d[4] = ~int_st[1];
        end
    end

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            rdata_q <= `USOC_BYTE_RST;
            op_out_q <= 8'hff;
            op_oen_q <= 8'h00;
            txa_vld_q <= 1'b0;
            txb_vld_q <= 1'b0;
            txa_dat_q <= `USOC_BYTE_RST;
            txb_dat_q <= `USOC_BYTE_RST;
        end else begin
            rdata_q <= I_RD ? rdata_d : `USOC_BYTE_RST;
            op_out_q <= op_out_d;
            op_oen_q <= op_oen_d;
            txa_vld_q <= txa_vld & ~I_TXA_TAKE;
            txb_vld_q <= txb_vld & ~I_TXB_TAKE;
            txa_dat_q <= txa_dat;
            txb_dat_q <= txb_dat;
        end
    end

    assign O_RDATA = rdata_q;
    assign O_OP_OUT = op_out_q;
    assign O_OP_OE_N = op_oen_q;
    assign O_IRQ = irq_q;
    assign O_TXA_VALID = txa_vld_q;
    assign O_TXA_DATA = txa_dat_q;
    assign O_TXB_VALID = txb_vld_q;
    assign O_TXB_DATA = txb_dat_q;
endmodule // usoc_top

// File: rtl/usoc_regs.vh
// Purpose: constants of the serial status and output configuration block
// Assumes: 8-bit register port with a 4-bit word address
// Notes: offsets are word indexes on the plain register port
`ifndef USOC_REGS_VH
`define USOC_REGS_VH

// register word addresses
`define USOC_A_MODE_A 4'h0
`define USOC_A_STAT_A 4'h1
`define USOC_A_CMD_A 4'h2
`define USOC_A_DATA_A 4'h3
`define USOC_A_EVT 4'h4
`define USOC_A_MASK 4'h5
`define USOC_A_INTST 4'h6
`define USOC_A_OPV 4'h7
`define USOC_A_MODE_B 4'h8
`define USOC_A_STAT_B 4'h9
`define USOC_A_CMD_B 4'ha
`define USOC_A_DATA_B 4'hb
`define USOC_A_PINCFG 4'hd

// mode register fields
`define USOC_MODE_FIFO8 3
`define USOC_MODE_BLK 5
`define USOC_MODE_RXINT 6

// command register fields
`define USOC_CMD_CODE 7:4
`define USOC_CMD_RX_RST 4'h2
`define USOC_CMD_TX_RST 4'h3
`define USOC_CMD_ERR_RST 4'h4
`define USOC_CMD_TX_EN 2
`define USOC_CMD_TX_DIS 3

// status register fields
`define USOC_ST_ERR 7:5
`define USOC_ST_OVR 4
`define USOC_ST_TXEMT 3
`define USOC_ST_TXRDY 2
`define USOC_ST_FULL 1
`define USOC_ST_RDY 0

// event register bits
`define USOC_EV_RDY_A 0
`define USOC_EV_OVR_A 1
`define USOC_EV_RDY_B 2
`define USOC_EV_OVR_B 3

// fifo depths and reset values
`define USOC_DEPTH_DEEP 16
`define USOC_DEPTH_COMPAT 8
`define USOC_BYTE_RST 8'h00
`define USOC_EVT_RST 4'h0

`endif

// File: rtl/usoc_chan.v
// Purpose: one serial channel: receive FIFO with error bits, transmit FIFO, status
// Assumes: characters arrive from the receive shift logic as one-cycle pulses
// Notes: the first character past a full FIFO is held in a one-character shift stage, later ones are dropped
`timescale 1ns/100ps
`include "usoc_regs.vh"

module usoc_chan #(
    parameter DEPTH = `USOC_DEPTH_DEEP,
    parameter AW = 4
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // configuration and commands
    input wire i_fifo8,
    input wire i_blk_mode,
    input wire i_rx_rst,
    input wire i_tx_rst,
    input wire i_err_rst,
    input wire i_tx_en,
    input wire i_tx_dis,
    // receive side
    input wire i_rx_valid,
    input wire [7:0] i_rx_data,
    input wire [2:0] i_rx_err,
    input wire i_rd,
    output wire [7:0] o_rx_data,
    // transmit side
    input wire i_wr,
    input wire [7:0] i_wdata,
    input wire i_tx_take,
    output wire o_tx_valid,
    output wire [7:0] o_tx_data,
    // status
    output wire [7:0] o_status
);
    localparam [AW:0] LIM_DEEP = DEPTH;
    localparam [AW:0] LIM_COMPAT = `USOC_DEPTH_COMPAT;
    localparam [AW:0] ONE = 1;
    localparam [AW:0] ZERO = 0;

    reg [7:0] rx_mem [0:DEPTH-1];
    reg [2:0] rx_err [0:DEPTH-1];
    reg [7:0] tx_mem [0:DEPTH-1];
    reg [AW-1:0] rx_wp_q, rx_rp_q, tx_wp_q, tx_rp_q;
    reg [AW:0] rx_cnt_q, tx_cnt_q;
    reg sh_vld_q, full_q, rdy_q, ovr_q, tx_en_q;
    reg [7:0] sh_dat_q;
    reg [2:0] sh_err_q, blk_q;
    integer k;

    wire [AW:0] lim = i_fifo8 ? LIM_COMPAT : LIM_DEEP;
    wire rx_pop = i_rd & (rx_cnt_q != ZERO);
    wire is_full = (rx_cnt_q == lim);
    wire push = (sh_vld_q & rx_pop) | (i_rx_valid & ~sh_vld_q & (~is_full | rx_pop));
    wire [7:0] push_dat = sh_vld_q ? sh_dat_q : i_rx_data;
    wire [2:0] push_err = sh_vld_q ? sh_err_q : i_rx_err;
    wire ovr_ev = i_rx_valid & sh_vld_q & ~rx_pop;
    wire [AW:0] rx_cnt_d = rx_cnt_q + (push ? ONE : ZERO) - (rx_pop ? ONE : ZERO);
    wire tx_push = i_wr & tx_en_q & (tx_cnt_q < lim);
    wire tx_pop = i_tx_take & (tx_cnt_q != ZERO);

    ////////////////////////////////////////////////////////////////////////////
    // receive FIFO and shift stage
    always @(posedge clk) begin
        if (!rst_n || i_rx_rst) begin
            rx_wp_q <= {AW{1'b0}};
            rx_rp_q <= {AW{1'b0}};
            rx_cnt_q <= ZERO;
            sh_vld_q <= 1'b0;
            sh_dat_q <= `USOC_BYTE_RST;
            sh_err_q <= 3'h0;
            full_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            if (i_err_rst && !i_blk_mode) begin
                for (k = 0; k < DEPTH; k = k + 1) begin
                    rx_err[k] <= 3'h0;
                end
            end
            if (push) begin
                rx_mem[rx_wp_q] <= push_dat;
                rx_err[rx_wp_q] <= push_err;
                rx_wp_q <= (rx_wp_q + ONE[AW-1:0]) & (lim[AW-1:0] - ONE[AW-1:0]);
            end
            if (rx_pop) begin
                rx_rp_q <= (rx_rp_q + ONE[AW-1:0]) & (lim[AW-1:0] - ONE[AW-1:0]);
            end
            if (sh_vld_q && rx_pop) begin
                sh_vld_q <= i_rx_valid;
                sh_dat_q <= i_rx_data;
                sh_err_q <= i_rx_err;
            end else if (!sh_vld_q && i_rx_valid && is_full && !rx_pop) begin
                sh_vld_q <= 1'b1;
                sh_dat_q <= i_rx_data;
                sh_err_q <= i_rx_err;
            end
            rx_cnt_q <= rx_cnt_d;
            full_q <= (rx_cnt_d == lim);
            rdy_q <= (rx_cnt_d != ZERO);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overrun and block error accumulation, set wins over clear
    always @(posedge clk) begin
        if (!rst_n) begin
            ovr_q <= 1'b0;
            blk_q <= 3'h0;
        end else begin
            ovr_q <= (ovr_q & ~i_err_rst) | ovr_ev;
            blk_q <= ((i_err_rst | i_rx_rst) ? 3'h0 : blk_q) | (push ? push_err : 3'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit FIFO
    always @(posedge clk) begin
        if (!rst_n || i_tx_rst) begin
            tx_wp_q <= {AW{1'b0}};
            tx_rp_q <= {AW{1'b0}};
            tx_cnt_q <= ZERO;
            tx_en_q <= 1'b0;
        end else begin
            if (i_tx_dis) begin
                tx_en_q <= 1'b0;
            end else if (i_tx_en) begin
                tx_en_q <= 1'b1;
            end
            if (tx_push) begin
                tx_mem[tx_wp_q] <= i_wdata;
                tx_wp_q <= (tx_wp_q + ONE[AW-1:0]) & (lim[AW-1:0] - ONE[AW-1:0]);
            end
            if (tx_pop) begin
                tx_rp_q <= (tx_rp_q + ONE[AW-1:0]) & (lim[AW-1:0] - ONE[AW-1:0]);
            end
            tx_cnt_q <= tx_cnt_q + (tx_push ? ONE : ZERO) - (tx_pop ? ONE : ZERO);
        end
    end

    assign o_rx_data = rx_mem[rx_rp_q];
    assign o_tx_valid = tx_cnt_q != ZERO;
    assign o_tx_data = tx_mem[tx_rp_q];
    assign o_status[`USOC_ST_ERR] = i_blk_mode ? blk_q : (rdy_q ? rx_err[rx_rp_q] : 3'h0);
    assign o_status[`USOC_ST_OVR] = ovr_q;
    assign o_status[`USOC_ST_TXEMT] = tx_en_q & (tx_cnt_q == ZERO);
    assign o_status[`USOC_ST_TXRDY] = tx_en_q & (tx_cnt_q < lim);
    assign o_status[`USOC_ST_FULL] = full_q;
    assign o_status[`USOC_ST_RDY] = rdy_q;
endmodule // usoc_chan

// File: verif/usoc_top_monitor.sv
// Purpose: port-level checker for the serial status and output configuration block
// Assumes: single clock domain, synchronous active low reset
// Notes: bound to the top module from the testbench top file
`timescale 1ns/100ps
module usoc_top_monitor #(
    parameter DEPTH = 16
) (
    input wire I_MCLK,
    input wire I_RST_N,
    input wire [3:0] I_ADDR,
    input wire [7:0] I_WDATA,
    input wire I_WR,
    input wire I_RD,
    input wire [7:0] O_RDATA,
    input wire I_RXA_VALID,
    input wire I_RXB_VALID,
    input wire I_TXA_TAKE,
    input wire O_TXA_VALID,
    input wire [7:0] O_OP_OUT,
    input wire [7:0] O_OP_OE_N
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    ////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
        else $error("read data not idle");
    unmapped_read_a: assert property (I_RD && I_ADDR == 4'hc |=> O_RDATA == 8'h00)
        else $error("unmapped read not zero");
    opv_pins_a: assert property ((I_WR && I_ADDR == 4'h7) ##1 !(I_WR && I_ADDR == 4'h7)
        |=> O_OP_OUT[3:0] == ~$past(I_WDATA[3:0], 2))
        else $error("low pins not inverse of port value");
    low_pins_a: assert property (O_OP_OE_N[3:0] == 4'h0)
        else $error("low pins not driven");
    take_drop_a: assert property (I_TXA_TAKE |=> !O_TXA_VALID)
        else $error("tx valid stayed after take");
    ready_a_a: assert property (I_RXA_VALID ##1 !I_RD ##1 (I_RD && I_ADDR == 4'h1)
        |=> O_RDATA[0])
        else $error("ready A missing after push");
    ready_b_a: assert property (I_RXB_VALID ##1 !I_RD ##1 (I_RD && I_ADDR == 4'h9)
        |=> O_RDATA[0])
        else $error("ready B missing after push");
    err_clear_a: assert property ((I_WR && I_ADDR == 4'h2 && I_WDATA[7:4] == 4'h4
        && !I_RXA_VALID) ##1 (!I_RXA_VALID && !I_RD) ##1 (I_RD && I_ADDR == 4'h1)
        |=> O_RDATA[7:4] == 4'h0)
        else $error("error bits kept after error reset");
    cover property (I_RXA_VALID);
    cover property (I_TXA_TAKE);
    cover property (I_WR && I_ADDR == 4'h2 && I_WDATA[7:4] == 4'h4);
endmodule // usoc_top_monitor

// File: verif/usoc_host.sv
// Purpose: host processor model on the plain register port
// Assumes: strobes one cycle, read data in the cycle after the strobe
// Notes: tasks are called from the testbench
`timescale 1ns/100ps
module usoc_host (
    // clock
    input wire i_clk,
    // register port
    input wire [7:0] i_rdata,
    output logic [3:0] o_addr,
    output logic [7:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 4'h0;
        o_wdata = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(negedge i_clk);
        d = i_rdata;
    endtask
    // host clears accumulated errors with the error reset command
    task err_rst(input logic [3:0] a);
        wr(a, 8'h40);
    endtask
endmodule // usoc_host

// File: verif/test_uart_status_and_output_config.sv
// Purpose: self-checking bench of the serial status and output configuration block
// Assumes: 20 MHz clock, reset held 6 cycles
// Notes: table rows first, then hand-written fifo, error, tx and pin cases
`timescale 1ns/100ps
module test_uart_status_and_output_config;
    logic clk = 1'b0, rst_n = 1'b0;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, d, op_out, op_oe_n, txa_d, txb_d;
    logic wr, rd, irq, txa_v, txb_v, txa_take = 1'b0, rxa_v = 1'b0, rxb_v = 1'b0;
    logic [7:0] rx_d = 8'h00;
    logic [2:0] rx_e = 3'h0;
    logic [19:0] rows [0:5];
    int mismatches = 0, compares = 0, n;
    always #25 clk = ~clk;
    usoc_host host_i (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));
    usoc_top usoc_top_i (.I_MCLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_RXA_VALID(rxa_v), .I_RXA_DATA(rx_d),
        .I_RXA_ERR(rx_e), .I_TXA_TAKE(txa_take), .O_TXA_VALID(txa_v), .O_TXA_DATA(txa_d),
        .I_RXB_VALID(rxb_v), .I_RXB_DATA(rx_d), .I_RXB_ERR(rx_e), .I_TXB_TAKE(txa_take),
        .O_TXB_VALID(txb_v), .O_TXB_DATA(txb_d), .O_OP_OUT(op_out), .O_OP_OE_N(op_oe_n),
        .O_IRQ(irq));
    ////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task finish_test;
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task push(input logic ch, input logic [7:0] dt, input logic [2:0] er);
        @(posedge clk);
        rxa_v <= !ch;
        rxb_v <= ch;
        rx_d <= dt;
        rx_e <= er;
        @(posedge clk);
        rxa_v <= 1'b0;
        rxb_v <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        rows = '{{4'hd, 8'h00, 8'h00}, {4'h7, 8'h3c, 8'h3c}, {4'h5, 8'h0f, 8'h0f},
            {4'hc, 8'hff, 8'h00}, {4'h9, 8'hff, 8'h00}, {4'h6, 8'hff, 8'h00}};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            host_i.wr(rows[i][19:16], rows[i][15:8]);
            host_i.rd(rows[i][19:16], d);
            chk("reg", d, rows[i][7:0]);
        end
        chk("pins", op_out, 8'hc3);
        chk("pins_oe", op_oe_n, 8'h00);
        // eight-deep receive fifo filled past full
        host_i.wr(4'h0, 8'h08);
        for (int k = 0; k < 10; k++) begin
            push(1'b0, k[7:0], k[2:0]);
            if (k == 6 || k == 7) begin
                host_i.rd(4'h1, d);
                chk("fullA", {7'h0, d[1]}, {7'h0, k == 7});
            end
        end
        host_i.rd(4'h1, d);
        chk("ovrA", d, 8'h13);
        host_i.rd(4'h4, d);
        chk("events", d, 8'h03);
        chk("irq", {7'h0, irq}, 8'h01);
        host_i.wr(4'h5, 8'h00);
        host_i.rd(4'h4, d);
        chk("irq_mask", {7'h0, irq}, 8'h00);
        host_i.wr(4'h5, 8'h0f);
        host_i.wr(4'h4, 8'h0f);
        host_i.rd(4'h4, d);
        chk("ev_clr", d, 8'h00);
        chk("irq_clr", {7'h0, irq}, 8'h00);
        for (int k = 0; k < 9; k++) begin
            host_i.rd(4'h1, d);
            chk("headA", {4'h0, d[7:5], d[1]}, {4'h0, k[2:0], k < 2});
            host_i.rd(4'h3, d);
            chk("rxA", d, k[7:0]);
        end
        host_i.rd(4'h1, d);
        chk("emptyA", d, 8'h10);
        host_i.err_rst(4'h2);
        host_i.rd(4'h1, d);
        chk("errrstA", d, 8'h00);
        // block error mode on channel B
        host_i.wr(4'h8, 8'h20);
        push(1'b1, 8'h55, 3'b100);
        host_i.rd(4'h9, d);
        chk("stB", d, 8'h81);
        push(1'b1, 8'h66, 3'b001);
        host_i.rd(4'hb, d);
        host_i.rd(4'h9, d);
        chk("blkB", d, 8'ha1);
        host_i.rd(4'hb, d);
        host_i.err_rst(4'ha);
        push(1'b1, 8'h77, 3'b000);
        host_i.rd(4'h9, d);
        chk("blk_clr", d, 8'h01);
        host_i.rd(4'hb, d);
        chk("rxB", d, 8'h77);
        // transmitter and interrupt driven pins
        host_i.wr(4'h2, 8'h04);
        host_i.rd(4'h1, d);
        chk("txA_on", d, 8'h0c);
        host_i.wr(4'hd, 8'hf0);
        host_i.rd(4'h6, d);
        chk("isr", d, 8'h01);
        chk("pin_oe", op_oe_n, 8'hb0);
        chk("pin_out", {3'h0, op_out[6], op_out[3:0]}, 8'h03);
        host_i.wr(4'ha, 8'h04);
        host_i.wr(4'hb, 8'h5a);
        host_i.wr(4'h3, 8'ha7);
        n = 0;
        while (txa_v !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        if (txa_v !== 1'b1) begin
            mismatches++;
            finish_test;
        end
        chk("txA", txa_d, 8'ha7);
        chk("txB", {7'h0, txb_v} ^ txb_d, 8'h5b);
        @(posedge clk);
        txa_take <= 1'b1;
        @(posedge clk);
        txa_take <= 1'b0;
        @(negedge clk);
        chk("take", {7'h0, txa_v}, 8'h00);
        chk("takeB", {7'h0, txb_v}, 8'h00);
        host_i.wr(4'h2, 8'h08);
        host_i.wr(4'ha, 8'h08);
        host_i.rd(4'h1, d);
        chk("txA_off", {6'h0, d[3:2]}, 8'h00);
        // interrupt bit reports full rather than ready
        host_i.wr(4'h0, 8'h48);
        push(1'b0, 8'h11, 3'b000);
        host_i.rd(4'h1, d);
        chk("st_rxint", d, 8'h01);
        host_i.rd(4'h6, d);
        chk("isr_rxint", d, 8'h00);
        // mid-run reset returns pins, interrupt and status to idle
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("rst_pins", op_out, 8'hff);
        chk("rst_oe", op_oe_n, 8'h00);
        chk("rst_irq", {6'h0, irq, txb_v}, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        host_i.rd(4'h1, d);
        chk("rst_stA", d, 8'h00);
        finish_test;
    end
endmodule // test_uart_status_and_output_config

bind usoc_top usoc_top_monitor #(.DEPTH(DEPTH)) mon_i (.I_MCLK(I_MCLK), .I_RST_N(I_RST_N),
    .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_RXA_VALID(I_RXA_VALID), .I_RXB_VALID(I_RXB_VALID), .I_TXA_TAKE(I_TXA_TAKE),
    .O_TXA_VALID(O_TXA_VALID), .O_OP_OUT(O_OP_OUT), .O_OP_OE_N(O_OP_OE_N));
